// ---- logic/ext_irq_and_vector_select.v ----
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_defines.vh"

// What this block does
// - select bit places table at flash or boot
// - block servicing during change window
// - global enable flag left untouched
// - change enable self-clears after four cycles
// - lock bits suppress interrupts across sections
// - pins trigger even when driven as outputs
// - three change groups over their pin ranges
// - per-pin masks gate change groups
// - pin change detected without clock edge
// - low level requests while pin low
// - edge detection uses the clock
// - low level detected without clock edge
// - level gone before start-up gives no interrupt
// - request needs global and individual enable
// - pins sampled once before edge detection
// - sense field one selects trigger type
// - sense register upper bits read zero
// - sense field zero uses same encoding
// - external flags set on edge, cleared
// - group flags set on change, cleared
module ext_irq_and_vector_select
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        ext_irq_pin_0,
    input  wire        ext_irq_pin_1,
    input  wire [23:0] change_detect_pins,
    input  wire        global_irq_enable,
    input  wire        app_section_lock_bit,
    input  wire        boot_section_lock_bit,
    input  wire        exec_in_boot_section,
    input  wire [1:0]  boot_size_fuses,
    input  wire        irq_ack,
    input  wire [2:0]  irq_ack_index,
    output reg         irq_request,
    output reg  [2:0]  irq_index,
    output reg  [15:0] irq_vector_addr,
    output reg         wake_request
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state.

    reg        vector_table_select_q;
    reg        vector_change_enable_q;
    reg [2:0]  change_count_q;
    reg        block_tail_q;
    reg [3:0]  sense_q;
    reg [1:0]  ext_enable_q;
    reg [1:0]  ext_flag_q;
    reg [2:0]  grp_enable_q;
    reg [2:0]  grp_flag_q;
    reg [7:0]  change_mask_group_0_q;
    reg [6:0]  change_mask_group_1_q;
    reg [7:0]  change_mask_group_2_q;
    reg        ext0_sample_q;
    reg        ext1_sample_q;
    reg [23:0] pin_ref_q;

    // Data phase bookkeeping for the bus.
    reg        wr_pend_q;
    reg [7:0]  wr_addr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    wire       addr_phase = hsel & hready & htrans[1];
    wire [7:0] addr_lo    = haddr[7:0];
    wire       wr_now     = wr_pend_q;
    wire [7:0] wdat       = hwdata[7:0];

    wire wr_mcu   = wr_now & (wr_addr_q == `OFF_MCU_CONTROL);
    wire wr_sense = wr_now & (wr_addr_q == `OFF_SENSE_CONTROL);
    wire wr_eena  = wr_now & (wr_addr_q == `OFF_EXT_ENABLE);
    wire wr_eflg  = wr_now & (wr_addr_q == `OFF_EXT_FLAGS);
    wire wr_gena  = wr_now & (wr_addr_q == `OFF_CHANGE_ENABLE);
    wire wr_gflg  = wr_now & (wr_addr_q == `OFF_CHANGE_FLAGS);
    wire wr_msk0  = wr_now & (wr_addr_q == `OFF_CHANGE_MASK_0);
    wire wr_msk1  = wr_now & (wr_addr_q == `OFF_CHANGE_MASK_1);
    wire wr_msk2  = wr_now & (wr_addr_q == `OFF_CHANGE_MASK_2);

    ////////////////////////////////////////////////////////////////////////////
    // Pin detection.

    // Edge detectors compare the raw pin with the previous sample, so a pulse
    // longer than one clock period is always seen.
    wire ext0_rise = ext_irq_pin_0 & ~ext0_sample_q;
    wire ext0_fall = ~ext_irq_pin_0 & ext0_sample_q;
    wire ext1_rise = ext_irq_pin_1 & ~ext1_sample_q;
    wire ext1_fall = ~ext_irq_pin_1 & ext1_sample_q;

    reg [1:0] ext_edge;

    // Trigger selection per sense field; level mode sets no flag.
    always @*
    begin
        case (sense_q[1:0])
            `SENSE_ANY:  ext_edge[0] = ext0_rise | ext0_fall;
            `SENSE_FALL: ext_edge[0] = ext0_fall;
            `SENSE_RISE: ext_edge[0] = ext0_rise;
            default:     ext_edge[0] = 1'b0;
        endcase
        case (sense_q[3:2])
            `SENSE_ANY:  ext_edge[1] = ext1_rise | ext1_fall;
            `SENSE_FALL: ext_edge[1] = ext1_fall;
            `SENSE_RISE: ext_edge[1] = ext1_rise;
            default:     ext_edge[1] = 1'b0;
        endcase
    end

    // Level mode reads the raw pin, so no clock edge is needed to see it.
    wire [1:0] ext_level;
    assign ext_level[0] = (sense_q[1:0] == `SENSE_LOW) & ~ext_irq_pin_0;
    assign ext_level[1] = (sense_q[3:2] == `SENSE_LOW) & ~ext_irq_pin_1;

    // Pin change is a mismatch between pin and reference, with no edge
    // detector in the path; the pins are read whatever their direction.
    wire [23:0] pin_diff = change_detect_pins ^ pin_ref_q;
    wire [23:0] pin_mask = {change_mask_group_2_q, 1'b0, change_mask_group_1_q,
                            change_mask_group_0_q};
    wire [23:0] pin_hit  = pin_diff & pin_mask;
    wire [2:0]  grp_hit  = {|pin_hit[23:16], |pin_hit[14:8], |pin_hit[7:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge decode.

    // One bit per source code; code zero names no source.
    wire [7:0] ack_hot = irq_ack ? (8'h01 << irq_ack_index) : 8'h00;

    wire [1:0] ext_clr = ({2{wr_eflg}} & wdat[1:0]) | ack_hot[`SRC_EXT1:`SRC_EXT0];
    wire [2:0] grp_clr = ({3{wr_gflg}} & wdat[2:0]) | ack_hot[`SRC_GRP2:`SRC_GRP0];

    ////////////////////////////////////////////////////////////////////////////
    // Vector change protection.

    // The window blocks servicing without touching the global enable input;
    // that flag lives in the core and this block only reads it.
    wire change_open  = change_count_q != 3'd0;
    wire start_change = wr_mcu & wdat[`BIT_VECTOR_CHANGE];
    wire write_select = wr_mcu & change_open & ~wdat[`BIT_VECTOR_CHANGE];
    wire irq_block    = change_open | block_tail_q;

    // Lock bits suppress servicing from the other section.
    wire lock_block = (vector_table_select_q & app_section_lock_bit & ~exec_in_boot_section)
                    | (~vector_table_select_q & boot_section_lock_bit
                       & exec_in_boot_section);

    ////////////////////////////////////////////////////////////////////////////
    // Request arbitration.

    wire [1:0] ext_pend = (ext_flag_q | ext_level) & ext_enable_q;
    wire [2:0] grp_pend = grp_flag_q & grp_enable_q;
    wire       may_serve = global_irq_enable & ~irq_block & ~lock_block;

    reg        req_d;
    reg [2:0]  idx_d;
    reg [15:0] off_d;
    reg [15:0] boot_base;

    // Lowest vector wins.
    always @*
    begin
        req_d = may_serve & ((|ext_pend) | (|grp_pend));
        idx_d = 3'd0;
        off_d = 16'h0000;
        if (ext_pend[0])
        begin
            idx_d = `SRC_EXT0;
            off_d = `VEC_OFF_EXT0;
        end
        else if (ext_pend[1])
        begin
            idx_d = `SRC_EXT1;
            off_d = `VEC_OFF_EXT1;
        end
        else if (grp_pend[0])
        begin
            idx_d = `SRC_GRP0;
            off_d = `VEC_OFF_GRP0;
        end
        else if (grp_pend[1])
        begin
            idx_d = `SRC_GRP1;
            off_d = `VEC_OFF_GRP1;
        end
        else if (grp_pend[2])
        begin
            idx_d = `SRC_GRP2;
            off_d = `VEC_OFF_GRP2;
        end
        case (boot_size_fuses)
            2'd0:    boot_base = `BOOT_BASE_0;
            2'd1:    boot_base = `BOOT_BASE_1;
            2'd2:    boot_base = `BOOT_BASE_2;
            default: boot_base = `BOOT_BASE_3;
        endcase
    end

    wire [15:0] table_base = vector_table_select_q ? boot_base : `FLASH_BASE;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux, computed in the address phase.

    reg [7:0] rd_d;

    always @*
    begin
        case (addr_lo)
            `OFF_MCU_CONTROL:   rd_d = {6'd0, vector_table_select_q, vector_change_enable_q};
            `OFF_SENSE_CONTROL: rd_d = {4'd0, sense_q};
            `OFF_EXT_ENABLE:    rd_d = {6'd0, ext_enable_q};
            `OFF_EXT_FLAGS:     rd_d = {6'd0, ext_flag_q};
            `OFF_CHANGE_ENABLE: rd_d = {5'd0, grp_enable_q};
            `OFF_CHANGE_FLAGS:  rd_d = {5'd0, grp_flag_q};
            `OFF_CHANGE_MASK_0: rd_d = change_mask_group_0_q;
            `OFF_CHANGE_MASK_1: rd_d = {1'b0, change_mask_group_1_q};
            `OFF_CHANGE_MASK_2: rd_d = change_mask_group_2_q;
            default:            rd_d = `RST_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait states, always OKAY.

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= `RST_BYTE;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= addr_phase & hwrite;
            if (addr_phase)
                wr_addr_q <= addr_lo;
            if (addr_phase & ~hwrite)
                hrdata <= {24'h00_0000, rd_d};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Vector select and its protected change window.

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vector_table_select_q  <= 1'b0;
            vector_change_enable_q <= 1'b0;
            change_count_q         <= 3'd0;
            block_tail_q           <= 1'b0;
        end
        else
        begin
            block_tail_q <= 1'b0;
            if (start_change)
            begin
                // Setting the enable never moves the table by itself.
                vector_change_enable_q <= 1'b1;
                change_count_q         <= `CHANGE_WINDOW_CYCLES;
            end
            else if (write_select)
            begin
                // One extra blocked cycle covers the following instruction.
                vector_table_select_q  <= wdat[`BIT_VECTOR_SELECT];
                vector_change_enable_q <= 1'b0;
                change_count_q         <= 3'd0;
                block_tail_q           <= 1'b1;
            end
            else if (change_open)
            begin
                change_count_q <= change_count_q - 3'd1;
                if (change_count_q == 3'd1)
                    vector_change_enable_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sense_q               <= 4'd0;
            ext_enable_q          <= 2'd0;
            grp_enable_q          <= 3'd0;
            change_mask_group_0_q <= 8'h00;
            change_mask_group_1_q <= 7'h00;
            change_mask_group_2_q <= 8'h00;
        end
        else
        begin
            if (wr_sense)
                sense_q <= wdat[3:0];
            if (wr_eena)
                ext_enable_q <= wdat[1:0];
            if (wr_gena)
                grp_enable_q <= wdat[2:0];
            if (wr_msk0)
                change_mask_group_0_q <= wdat;
            if (wr_msk1)
                change_mask_group_1_q <= wdat[6:0];
            if (wr_msk2)
                change_mask_group_2_q <= wdat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Samples and flags; a new event wins over a clear in the same cycle.

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext0_sample_q <= 1'b1;
            ext1_sample_q <= 1'b1;
            pin_ref_q     <= 24'h00_0000;
            ext_flag_q    <= 2'd0;
            grp_flag_q    <= 3'd0;
        end
        else
        begin
            ext0_sample_q <= ext_irq_pin_0;
            ext1_sample_q <= ext_irq_pin_1;
            pin_ref_q     <= change_detect_pins;
            // Level mode keeps the flag clear.
            ext_flag_q[0] <= (sense_q[1:0] != `SENSE_LOW)
                           & (ext_edge[0] | (ext_flag_q[0] & ~ext_clr[0]));
            ext_flag_q[1] <= (sense_q[3:2] != `SENSE_LOW)
                           & (ext_edge[1] | (ext_flag_q[1] & ~ext_clr[1]));
            grp_flag_q    <= grp_hit | (grp_flag_q & ~grp_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request and wake outputs.

    // A level that has gone again by now raises no request.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_request     <= 1'b0;
            irq_index       <= 3'd0;
            irq_vector_addr <= 16'h0000;
            wake_request    <= 1'b0;
        end
        else
        begin
            irq_request     <= req_d;
            irq_index       <= req_d ? idx_d : 3'd0;
            irq_vector_addr <= req_d ? (table_base + off_d) : 16'h0000;
            wake_request    <= (|(ext_level & ext_enable_q))
                             | (|(grp_hit & grp_enable_q));
        end
    end

endmodule // ext_irq_and_vector_select

`default_nettype wire

// ---- logic/ext_irq_defines.vh ----
`ifndef EXT_IRQ_DEFINES_VH
`define EXT_IRQ_DEFINES_VH

// Register byte offsets on the bus.
`define OFF_MCU_CONTROL         8'h00
`define OFF_SENSE_CONTROL       8'h04
`define OFF_EXT_ENABLE          8'h08
`define OFF_EXT_FLAGS           8'h0C
`define OFF_CHANGE_ENABLE       8'h10
`define OFF_CHANGE_FLAGS        8'h14
`define OFF_CHANGE_MASK_0       8'h18
`define OFF_CHANGE_MASK_1       8'h1C
`define OFF_CHANGE_MASK_2       8'h20

// Field positions inside mcu_control.
`define BIT_VECTOR_SELECT       1
`define BIT_VECTOR_CHANGE       0

// Sense field encodings.
`define SENSE_LOW               2'b00
`define SENSE_ANY               2'b01
`define SENSE_FALL              2'b10
`define SENSE_RISE              2'b11

// Reset values.
`define RST_BYTE                8'h00

// Protected change window length in cycles.
`define CHANGE_WINDOW_CYCLES    3'd4

// Vector table offsets in words, relative to the table base.
`define VEC_OFF_EXT0            16'h0002
`define VEC_OFF_EXT1            16'h0004
`define VEC_OFF_GRP0            16'h0006
`define VEC_OFF_GRP1            16'h0008
`define VEC_OFF_GRP2            16'h000A

// Table base when vectors sit at flash start.
`define FLASH_BASE              16'h0000

// Boot section start word address per boot size fuse setting.
`define BOOT_BASE_0             16'h1C00
`define BOOT_BASE_1             16'h1E00
`define BOOT_BASE_2             16'h1F00
`define BOOT_BASE_3             16'h1F80

// Source index codes presented with a request.
`define SRC_EXT0                3'd1
`define SRC_EXT1                3'd2
`define SRC_GRP0                3'd3
`define SRC_GRP1                3'd4
`define SRC_GRP2                3'd5

`endif

// ---- verif/board_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module board_pins
(
    input  wire logic        hclk,
    input  wire logic        lvl_0,
    input  wire logic        lvl_1,
    input  wire logic [23:0] lvl_chg,
    output var  logic        ext_irq_pin_0,
    output var  logic        ext_irq_pin_1,
    output var  logic [23:0] change_detect_pins
);
    // Idle board levels before the first clock edge.
    initial
    begin
        ext_irq_pin_0      = 1'b1;
        ext_irq_pin_1      = 1'b1;
        change_detect_pins = 24'h00_0000;
    end
    // Levels move only after an edge, so every pulse spans a full clock period.
    // A low level is held until the bench releases it, never dropped early.
    always @(posedge hclk)
    begin
        ext_irq_pin_0      <= lvl_0;
        ext_irq_pin_1      <= lvl_1;
        change_detect_pins <= lvl_chg;
    end
endmodule // board_pins
`default_nettype wire

// ---- verif/ext_irq_checker_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_defines.vh"
module ext_irq_checker
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        ext_irq_pin_0,
    input wire logic        global_irq_enable,
    input wire logic [1:0]  boot_size_fuses,
    input wire logic        irq_request,
    input wire logic [2:0]  irq_index,
    input wire logic [15:0] irq_vector_addr,
    input wire logic        wake_request
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        wr_q;
    logic [7:0]  wa_q;
    logic [3:0]  sense_q;
    logic [1:0]  en_q;
    logic [2:0]  gen_q;
    logic [15:0] boot_base, vec_off;
    ////////////////////////////////////////////////////////////////////////////
    // Shadows of enables and sense; write data lands one cycle late.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q    <= 1'b0;
            wa_q    <= 8'h00;
            sense_q <= 4'h0;
            en_q    <= 2'b00;
            gen_q   <= 3'b000;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            wa_q <= haddr[7:0];
            if (wr_q && wa_q == `OFF_SENSE_CONTROL)
                sense_q <= hwdata[3:0];
            if (wr_q && wa_q == `OFF_EXT_ENABLE)
                en_q <= hwdata[1:0];
            if (wr_q && wa_q == `OFF_CHANGE_ENABLE)
                gen_q <= hwdata[2:0];
        end
    end
    // The vector may sit at either table base, so both are accepted.
    assign boot_base = boot_size_fuses[1] ? (boot_size_fuses[0] ? `BOOT_BASE_3 : `BOOT_BASE_2)
                                          : (boot_size_fuses[0] ? `BOOT_BASE_1 : `BOOT_BASE_0);
    assign vec_off = {12'h000, irq_index, 1'b0};
    ////////////////////////////////////////////////////////////////////////////
    sequence s_wr_mcu;
        hsel && hready && htrans[1] && hwrite && haddr[7:0] == `OFF_MCU_CONTROL;
    endsequence
    sequence s_ce_data;
        s_wr_mcu ##1 hwdata[`BIT_VECTOR_CHANGE];
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    a_rd_sense: assert property (
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] == `OFF_SENSE_CONTROL
        |=> hrdata == {28'h000_0000, sense_q}) else $error("sense readback wrong");
    a_idle_zero: assert property (
        !irq_request |-> irq_index == 3'd0 && irq_vector_addr == 16'h0000)
        else $error("index or vector set without request");
    a_req_index: assert property (
        irq_request |-> irq_index >= `SRC_EXT0 && irq_index <= `SRC_GRP2)
        else $error("request with bad index");
    a_vec_base: assert property (
        irq_request |-> (irq_vector_addr == `FLASH_BASE + vec_off)
                     || (irq_vector_addr == boot_base + vec_off))
        else $error("vector not base plus offset");
    a_gie_gate: assert property (!global_irq_enable |=> !irq_request)
        else $error("request while global enable low");
    a_no_enable: assert property (
        en_q == 2'b00 && gen_q == 3'b000 |=> !irq_request)
        else $error("request with all sources disabled");
    a_ce_block: assert property (s_ce_data |=> ##1 !irq_request [*2])
        else $error("request during vector change window");
    a_level_wake: assert property (
        en_q[0] && sense_q[1:0] == `SENSE_LOW && !ext_irq_pin_0 |=> wake_request)
        else $error("low level gives no wake");
endmodule // ext_irq_checker
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_defines.vh"
module testbench;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pin_0, pin_1;
    logic        lvl_0, lvl_1, gie, app_lock, boot_lock, in_boot, ack, req, wake;
    logic [1:0]  htrans, fuses;
    logic [2:0]  hsize, ack_idx, idx;
    logic [15:0] vec;
    logic [23:0] pins, lvl_chg;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [23:0] rows [0:9];
    int          errors = 0;
    int          compares = 0;
    assign hready = hreadyout;
    ////////////////////////////////////////////////////////////////////////////
    ext_irq_and_vector_select i_ext_irq_and_vector_select (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_irq_pin_0(pin_0), .ext_irq_pin_1(pin_1),
        .change_detect_pins(pins), .global_irq_enable(gie), .app_section_lock_bit(app_lock),
        .boot_section_lock_bit(boot_lock), .exec_in_boot_section(in_boot),
        .boot_size_fuses(fuses), .irq_ack(ack), .irq_ack_index(ack_idx),
        .irq_request(req), .irq_index(idx), .irq_vector_addr(vec), .wake_request(wake));
    board_pins i_board_pins (.hclk(hclk), .lvl_0(lvl_0), .lvl_1(lvl_1), .lvl_chg(lvl_chg),
        .ext_irq_pin_0(pin_0), .ext_irq_pin_1(pin_1), .change_detect_pins(pins));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, and a watchdog far beyond the run's length.
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    initial
    begin
        repeat (20000) @(posedge hclk);
        errors++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Outputs are looked at 1 ns past the edge, once settled.
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    // One single word transfer; waits on hready, never on a fixed count.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] w);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h00_0000, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, w};
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic set_pin(input int p, input logic v);
        @(posedge hclk);
        if (p == 0)
            lvl_0 <= v;
        else
            lvl_1 <= v;
        @(posedge hclk);
    endtask
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Rows hold address, write data and expected readback.
    initial
    begin
        {hresetn, hsel, hwrite, gie, app_lock, boot_lock, in_boot, ack} = 8'h00;
        {haddr, hwdata, htrans, hsize, ack_idx, fuses} = {64'h0, 2'b00, 3'b010, 3'd0, 2'd2};
        {lvl_0, lvl_1, lvl_chg} = {2'b11, 24'h00_0000};
        rows = '{24'h00_0200, 24'h04_FF0F, 24'h04_0505, 24'h08_FF03, 24'h10_FF07,
                 24'h18_FFFF, 24'h1C_FF7F, 24'h20_FFFF, 24'h40_FF00, 24'h14_FF00};
        do_reset();
        chk("hreadyout", 1'b1, hreadyout);
        chk("irq_request", 1'b0, req);
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b0, rows[i][23:16], 8'h00);
            chk("reset value", 32'h0000_0000, r);
        end
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b1, rows[i][23:16], rows[i][15:8]);
            bus(1'b0, rows[i][23:16], 8'h00);
            chk("readback", {24'h00_0000, rows[i][7:0]}, r);
        end
        // A mid-run reset clears the sense field.
        do_reset();
        bus(1'b0, `OFF_SENSE_CONTROL, 8'h00);
        chk("sense after reset", 32'h0000_0000, r);
        gie <= 1'b1;
        for (int p = 0; p < 2; p++)
            for (int m = 0; m < 4; m++)
            begin
                bus(1'b1, `OFF_SENSE_CONTROL, 8'(m << (2 * p)));
                bus(1'b1, `OFF_EXT_ENABLE, 8'(1 << p));
                bus(1'b1, `OFF_EXT_FLAGS, 8'h03);
                set_pin(p, 1'b0);
                tick(5);
                chk("irq_request", m != `SENSE_RISE, req);
                if (m != `SENSE_RISE)
                begin
                    chk("irq_index", `SRC_EXT0 + p, idx);
                    chk("vector", `VEC_OFF_EXT0 + 2 * p, vec);
                end
                bus(1'b0, `OFF_EXT_FLAGS, 8'h00);
                chk("ext flags", (m == 1 || m == 2) ? (1 << p) : 0, r);
                ack     <= 1'b1;
                ack_idx <= 3'(`SRC_EXT0 + p);
                @(posedge hclk) ack <= 1'b0;
                tick(3);
                chk("irq_request", m == `SENSE_LOW, req);
                set_pin(p, 1'b1);
                tick(5);
                chk("irq_request", m == 1 || m == 3, req);
                bus(1'b1, `OFF_EXT_FLAGS, 8'h03);
                tick(3);
                chk("irq_request", 1'b0, req);
            end
        // A flag sets while global enable is low; the request waits.
        @(posedge hclk) gie <= 1'b0;
        bus(1'b1, `OFF_SENSE_CONTROL, 8'h02);
        bus(1'b1, `OFF_EXT_ENABLE, 8'h01);
        set_pin(0, 1'b0);
        tick(5);
        chk("irq_request", 1'b0, req);
        bus(1'b0, `OFF_EXT_FLAGS, 8'h00);
        chk("ext flags", 32'h0000_0001, r);
        gie <= 1'b1;
        tick(5);
        chk("irq_request", 1'b1, req);
        bus(1'b1, `OFF_EXT_FLAGS, 8'h03);
        set_pin(0, 1'b1);
        bus(1'b1, `OFF_EXT_ENABLE, 8'h00);
        bus(1'b1, `OFF_CHANGE_ENABLE, 8'h07);
        for (int g = 0; g < 3; g++)
        begin
            bus(1'b1, 8'(`OFF_CHANGE_MASK_0 + 4 * g), 8'h01);
            bus(1'b1, `OFF_CHANGE_FLAGS, 8'h07);
            lvl_chg[8 * g + 1] <= ~lvl_chg[8 * g + 1];
            tick(5);
            chk("irq_request", 1'b0, req);
            @(posedge hclk) lvl_chg[8 * g] <= ~lvl_chg[8 * g];
            tick(5);
            chk("irq_request", 1'b1, req);
            chk("irq_index", `SRC_GRP0 + g, idx);
            chk("vector", `VEC_OFF_GRP0 + 2 * g, vec);
            bus(1'b0, `OFF_CHANGE_FLAGS, 8'h00);
            chk("group flags", 1 << g, r);
            bus(1'b1, `OFF_CHANGE_FLAGS, 8'h07);
            tick(3);
            chk("irq_request", 1'b0, req);
        end
        bus(1'b1, `OFF_CHANGE_ENABLE, 8'h00);
        // A held low level is blocked while the window is open.
        bus(1'b1, `OFF_SENSE_CONTROL, 8'h00);
        bus(1'b1, `OFF_EXT_ENABLE, 8'h01);
        set_pin(0, 1'b0);
        tick(4);
        chk("wake_request", 1'b1, wake);
        bus(1'b1, `OFF_MCU_CONTROL, 8'h01);
        tick(2);
        chk("irq_request", 1'b0, req);
        bus(1'b0, `OFF_MCU_CONTROL, 8'h00);
        chk("mcu_control", 32'h0000_0001, r);
        tick(6);
        chk("irq_request", 1'b1, req);
        bus(1'b0, `OFF_MCU_CONTROL, 8'h00);
        chk("mcu_control", 32'h0000_0000, r);
        bus(1'b1, `OFF_MCU_CONTROL, 8'h01);
        bus(1'b1, `OFF_MCU_CONTROL, 8'h02);
        bus(1'b0, `OFF_MCU_CONTROL, 8'h00);
        chk("mcu_control", 32'h0000_0002, r);
        tick(5);
        chk("vector", `BOOT_BASE_2 + `VEC_OFF_EXT0, vec);
        @(posedge hclk) app_lock <= 1'b1;
        tick(5);
        chk("irq_request", 1'b0, req);
        @(posedge hclk) in_boot <= 1'b1;
        tick(5);
        chk("irq_request", 1'b1, req);
        set_pin(0, 1'b1);
        results();
    end
endmodule // testbench
bind ext_irq_and_vector_select ext_irq_checker i_ext_irq_checker (.*);
`default_nettype wire
